// ### bench/eem_decoder_model.sv
// Purpose: decoder stand-in that reports error events to the monitor
// Assumes: caller is 1 ns past a rising edge
// Notes: one event per call, then one idle cycle
`timescale 1ns/1ps
module eem_decoder_model
(
    input wire clk_i,
    output reg err_single_o = 1'b0,
    output reg err_double_o = 1'b0,
    output reg err_rmw_o = 1'b0,
    output reg err_lane_o = 1'b0,
    output reg [31:0] err_addr_o = 32'h0,
    output reg [127:0] err_data_o = 128'h0,
    output reg [15:0] err_syndrome_o = 16'h0
);
    // idle strobes drop and the other lines carry the inverse so stale values never look valid
    task fire(input dbl, input rmw, input lane, input [31:0] a, input [15:0] s);
    begin
        err_single_o = !dbl;
        err_double_o = dbl;
        err_rmw_o = rmw;
        err_lane_o = lane;
        err_addr_o = a;
        err_data_o = 128'h44444444333333332222222211111111;
        err_syndrome_o = s;
        @(posedge clk_i) #1 err_single_o = 1'b0;
        err_double_o = 1'b0;
        err_rmw_o = !rmw;
        err_lane_o = !lane;
        err_addr_o = ~a;
        err_data_o = ~err_data_o;
        err_syndrome_o = ~s;
        @(posedge clk_i) #1;
    end
    endtask
endmodule

// ### bench/eem_error_monitor_regs_assertions.sv
// Purpose: port-level checks of the error monitor register block
// Assumes: one clock, asynchronous active-high reset
// Notes: control and mask are shadowed from port writes
`timescale 1ns/1ps
module eem_error_monitor_regs_assertions
(
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] reg_port_addr_i,
    input wire [3:0] reg_port_byte_en_i,
    input wire reg_port_read_req_i,
    input wire reg_port_write_req_i,
    input wire [31:0] reg_port_wdata_i,
    input wire [31:0] reg_port_rdata_o,
    input wire reg_port_interrupt_o,
    input wire err_single_i,
    input wire err_double_i,
    input wire err_rmw_i,
    input wire err_lane_i,
    input wire [31:0] err_addr_i,
    input wire [127:0] err_data_i,
    input wire [15:0] err_syndrome_i,
    input wire correct_en_o,
    input wire corrupt_en_o,
    input wire corrupt_double_o
);
    reg [11:0] ctl;
    reg [4:0] mk;
    wire wr_c = reg_port_write_req_i && reg_port_addr_i == 4'h0;
    wire wr_k = reg_port_write_req_i && reg_port_addr_i == 4'hB && reg_port_byte_en_i[0];
    // ---------------------------------------------------------------
    // shadow state
    // ---------------------------------------------------------------
    // mask is write-only, so the checker has to remember it itself
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctl <= 12'h00F;
            mk <= 5'h01;
        end
        else
        begin
            if (wr_c && reg_port_byte_en_i[0])
                ctl[7:0] <= reg_port_wdata_i[7:0];
            if (wr_c && reg_port_byte_en_i[1])
                ctl[11:8] <= reg_port_wdata_i[11:8];
            if (wr_k)
                mk <= reg_port_wdata_i[4:0];
        end
    end
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    AST_MASK_READS_ZERO: assert property (reg_port_read_req_i &&
        reg_port_addr_i == 4'hB |=> reg_port_rdata_o == 32'h0) else $error("mask read not zero");
    AST_RDATA_HOLDS: assert property (!$past(reg_port_read_req_i) |->
        $stable(reg_port_rdata_o)) else $error("read data moved without a read");
    AST_CORRECT_EN: assert property (wr_c && reg_port_byte_en_i[0] |=> ##1
        correct_en_o == $past(reg_port_wdata_i[1], 2)) else $error("correct enable wrong");
    AST_CORRUPT_CTL: assert property (wr_c && reg_port_byte_en_i[1] |=> ##1
        {corrupt_double_o, corrupt_en_o} == $past(reg_port_wdata_i[9:8], 2))
        else $error("corrupt controls wrong");
    AST_SB_IRQ: assert property (err_single_i && !mk[0] && !reg_port_write_req_i
        ##1 !reg_port_write_req_i |-> ##[0:2] reg_port_interrupt_o)
        else $error("unmasked single error gave no interrupt");
    AST_DB_IRQ: assert property (err_double_i && ctl[2] && !mk[1] &&
        !reg_port_write_req_i ##1 !reg_port_write_req_i |-> ##[0:2] reg_port_interrupt_o)
        else $error("unmasked double error gave no interrupt");
    AST_IRQ_HOLDS: assert property ($fell(reg_port_interrupt_o) |->
        $past(reg_port_write_req_i) || $past(reg_port_write_req_i, 2)
        || $past(reg_port_write_req_i, 3)) else $error("interrupt dropped without a write");
    AST_CLR_ON_RD: assert property (reg_port_read_req_i && reg_port_addr_i == 4'h3 &&
        ctl[7] && !err_single_i ##1 reg_port_read_req_i && reg_port_addr_i == 4'h3
        && !err_single_i |=> reg_port_rdata_o == 32'h0) else $error("count not cleared");
    COV_IRQ_CLEARED: cover property (reg_port_interrupt_o ##1 !reg_port_interrupt_o);
    COV_RMW_DOUBLE: cover property (err_double_i && err_rmw_i);
    COV_KEEP_FIRST: cover property (ctl[10] && err_single_i);
endmodule

bind eem_error_monitor_regs eem_error_monitor_regs_assertions i_eem_error_monitor_regs_assertions
(
    .clk_i(clk_i), .rst_i(rst_i), .reg_port_addr_i(reg_port_addr_i),
    .reg_port_byte_en_i(reg_port_byte_en_i), .reg_port_read_req_i(reg_port_read_req_i),
    .reg_port_write_req_i(reg_port_write_req_i), .reg_port_wdata_i(reg_port_wdata_i),
    .reg_port_rdata_o(reg_port_rdata_o), .reg_port_interrupt_o(reg_port_interrupt_o),
    .err_single_i(err_single_i), .err_double_i(err_double_i), .err_rmw_i(err_rmw_i),
    .err_lane_i(err_lane_i), .err_addr_i(err_addr_i), .err_data_i(err_data_i),
    .err_syndrome_i(err_syndrome_i), .correct_en_o(correct_en_o),
    .corrupt_en_o(corrupt_en_o), .corrupt_double_o(corrupt_double_o)
);

// ### bench/eem_error_monitor_regs_tb.sv
// Purpose: directed register-level tests of the error monitor
// Assumes: inputs change 1 ns after the rising edge
// Notes: events come from the decoder model
`timescale 1ns/1ps
module eem_error_monitor_regs_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] addr = 4'h0;
    reg [3:0] be = 4'hF;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdata = 32'h0;
    wire [31:0] rdata;
    wire irq, ce, cen, cdb, e_s, e_d, e_r, e_l;
    wire [31:0] e_a;
    wire [127:0] e_dw;
    wire [15:0] e_sy;
    integer checks = 0;
    integer n_mismatch = 0;
    integer i;
    eem_error_monitor_regs i_eem_error_monitor_regs (.clk_i(clk), .rst_i(rst),
        .reg_port_addr_i(addr), .reg_port_byte_en_i(be), .reg_port_read_req_i(rd),
        .reg_port_write_req_i(wr), .reg_port_wdata_i(wdata), .reg_port_rdata_o(rdata),
        .reg_port_interrupt_o(irq), .err_single_i(e_s), .err_double_i(e_d), .err_rmw_i(e_r),
        .err_lane_i(e_l), .err_addr_i(e_a), .err_data_i(e_dw), .err_syndrome_i(e_sy),
        .correct_en_o(ce), .corrupt_en_o(cen), .corrupt_double_o(cdb));
    eem_decoder_model i_eem_decoder_model (.clk_i(clk), .err_single_o(e_s), .err_double_o(e_d),
        .err_rmw_o(e_r), .err_lane_o(e_l), .err_addr_o(e_a), .err_data_o(e_dw),
        .err_syndrome_o(e_sy));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task chk(input [31:0] seen, input [31:0] exp, input string what);
    begin
        checks = checks + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk) #1;
    endtask
    task wrr(input [3:0] a, input [31:0] d);
    begin
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk) #1 wr = 1'b0;
        tick(1);
    end
    endtask
    // keep leaves the request up so the next read follows back to back
    task rdc(input [3:0] a, input [31:0] e, input keep);
    begin
        addr = a;
        rd = 1'b1;
        if (keep)
            @(posedge clk) #1;
        else
            @(posedge clk) #1 rd = 1'b0;
        chk(rdata, e, $sformatf("reg %h", a));
        if (!keep)
            tick(1);
    end
    endtask
    task irq_is(input v);
        chk({31'h0, irq}, {31'h0, v}, "interrupt");
    endtask
    task finish_test;
    begin
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    // ---------------------------------------------------------------
    // clock, watchdog and tests
    // ---------------------------------------------------------------
    initial
        forever #5 clk = ~clk;
    // the tests need well under 1000 cycles
    initial
    begin
        #200000;
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        for (i = 0; i < 15; i = i + 1)
            rdc(i[3:0], (i == 0) ? 32'hF : (i == 1 || i == 2) ? 32'h1 : 32'h0,
                1'b0);
        chk({31'h0, ce}, 32'h1, "correct enable");
        wrr(4'h3, 32'hFFFFFFFF);
        rdc(4'h3, 32'h0, 1'b0);
        $display("test reset values done");
        i_eem_decoder_model.fire(1'b0, 1'b0, 1'b1, 32'hA1, 16'hB2A1);
        rdc(4'h3, 32'h1, 1'b0);
        rdc(4'h5, 32'hA1, 1'b0);
        rdc(4'hC, 32'h2, 1'b0);
        rdc(4'h8, 32'hA1, 1'b0);
        rdc(4'h7, 32'h11111111, 1'b1);
        rdc(4'h7, 32'h22222222, 1'b0);
        rdc(4'h8, 32'hB2, 1'b0);
        rdc(4'h7, 32'h33333333, 1'b0);
        rdc(4'h7, 32'h44444444, 1'b0);
        irq_is(1'b0);
        i_eem_decoder_model.fire(1'b0, 1'b0, 1'b0, 32'hA2, 16'h0);
        tick(2);
        irq_is(1'b1);
        rdc(4'h3, 32'h1, 1'b0);
        rdc(4'hA, 32'h5, 1'b0);
        wrr(4'hA, 32'h1);
        rdc(4'hA, 32'h4, 1'b0);
        irq_is(1'b1);
        wrr(4'hC, 32'h2);
        rdc(4'hC, 32'h1, 1'b0);
        wrr(4'hA, 32'h4);
        tick(2);
        irq_is(1'b0);
        $display("test single error done");
        wrr(4'hB, 32'h0);
        i_eem_decoder_model.fire(1'b1, 1'b0, 1'b0, 32'hB0, 16'h0);
        tick(2);
        irq_is(1'b1);
        rdc(4'h4, 32'h1, 1'b0);
        rdc(4'h6, 32'hB0, 1'b0);
        rdc(4'hA, 32'h2, 1'b0);
        rdc(4'hD, 32'h1, 1'b0);
        rdc(4'h9, 32'h11111111, 1'b0);
        irq_is(1'b1);
        wrr(4'h0, 32'h80F);
        tick(2);
        irq_is(1'b0);
        wrr(4'hA, 32'h1F);
        $display("test double error done");
        wrr(4'h0, 32'h01E);
        i_eem_decoder_model.fire(1'b0, 1'b0, 1'b0, 32'hC1, 16'h0);
        rdc(4'h3, 32'h0, 1'b0);
        wrr(4'h0, 32'h01B);
        i_eem_decoder_model.fire(1'b1, 1'b0, 1'b0, 32'hC2, 16'h0);
        rdc(4'h4, 32'h0, 1'b0);
        rdc(4'hA, 32'h1, 1'b0);
        wrr(4'h1, 32'h8);
        wrr(4'h0, 32'h41F);
        rdc(4'h5, 32'h0, 1'b0);
        i_eem_decoder_model.fire(1'b0, 1'b0, 1'b0, 32'h11, 16'h0);
        i_eem_decoder_model.fire(1'b0, 1'b0, 1'b0, 32'h22, 16'h0);
        rdc(4'h5, 32'h11, 1'b0);
        wrr(4'h0, 32'h00F);
        i_eem_decoder_model.fire(1'b0, 1'b0, 1'b0, 32'h33, 16'h0);
        rdc(4'h5, 32'h33, 1'b0);
        wrr(4'h0, 32'h08F);
        rdc(4'h3, 32'h3, 1'b1);
        rdc(4'h3, 32'h0, 1'b0);
        $display("test control modes done");
        wrr(4'hA, 32'h1F);
        wrr(4'hD, 32'h3);
        i_eem_decoder_model.fire(1'b1, 1'b1, 1'b1, 32'hD0, 16'h0);
        rdc(4'hA, 32'h12, 1'b0);
        i_eem_decoder_model.fire(1'b1, 1'b0, 1'b1, 32'hD1, 16'h0);
        rdc(4'hA, 32'h1A, 1'b0);
        rdc(4'h4, 32'h1, 1'b0);
        rdc(4'hD, 32'h2, 1'b0);
        wrr(4'h0, 32'h30D);
        chk({29'h0, cdb, cen, ce}, 32'h6, "datapath steering");
        be = 4'h2;
        wrr(4'h0, 32'h0);
        be = 4'hF;
        chk({29'h0, cdb, cen, ce}, 32'h0, "datapath steering");
        $display("test rmw and steering done");
        finish_test;
    end
endmodule

// ### pkg/eem_map.vh
// Purpose: register offsets, field positions and reset values of the error monitor
// Assumes: word-indexed register port, 32-bit data
// Notes: offsets are register indices on the request/address port
`ifndef EEM_MAP_VH
`define EEM_MAP_VH

// -----------------------------------------------------------------
// register indices
// -----------------------------------------------------------------
`define EEM_OFS_CTRL      4'h0
`define EEM_OFS_SB_THR    4'h1
`define EEM_OFS_DB_THR    4'h2
`define EEM_OFS_SB_CNT    4'h3
`define EEM_OFS_DB_CNT    4'h4
`define EEM_OFS_SB_ADDR   4'h5
`define EEM_OFS_DB_ADDR   4'h6
`define EEM_OFS_SB_DATA   4'h7
`define EEM_OFS_SB_SYN    4'h8
`define EEM_OFS_DB_DATA   4'h9
`define EEM_OFS_IRQ_STAT  4'hA
`define EEM_OFS_IRQ_MASK  4'hB
`define EEM_OFS_SB_LANE   4'hC
`define EEM_OFS_DB_LANE   4'hD

// -----------------------------------------------------------------
// control word fields
// -----------------------------------------------------------------
`define EEM_CTL_SB_COUNT   0
`define EEM_CTL_SB_CORRECT 1
`define EEM_CTL_DB_ENABLE  2
`define EEM_CTL_CLEAR_ALL  4
`define EEM_CTL_CLR_ON_RD  7
`define EEM_CTL_CORRUPT    8
`define EEM_CTL_CORR_TYPE  9
`define EEM_CTL_KEEP_FIRST 10
`define EEM_CTL_CLR_IRQ    11

// -----------------------------------------------------------------
// interrupt status / mask fields
// -----------------------------------------------------------------
`define EEM_IRQ_SB      0
`define EEM_IRQ_DB      1
`define EEM_IRQ_SB_MAX  2
`define EEM_IRQ_DB_MAX  3
`define EEM_IRQ_DB_RMW  4

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define EEM_RST_CTRL     32'h0000000F
`define EEM_RST_THR      32'h00000001
`define EEM_RST_MASK     5'h01

`endif

// ### rtl/eem_error_monitor_regs.v
// Purpose: control and status registers of a memory error-correction unit
// Assumes: decoder reports one error event per cycle with lane, syndrome and data
// Notes: lane count fixed at two 64-bit lanes (128-bit word); stored fields merge per byte enable, write-one clears and control actions ignore it
`timescale 1ns/1ps
`include "eem_map.vh"

module eem_error_monitor_regs
(
    input wire clk_i,
    input wire rst_i,
    // register port
    input wire [3:0] reg_port_addr_i,
    input wire [3:0] reg_port_byte_en_i,
    input wire reg_port_read_req_i,
    input wire reg_port_write_req_i,
    input wire [31:0] reg_port_wdata_i,
    output reg [31:0] reg_port_rdata_o,
    output reg reg_port_interrupt_o,
    // decoder event side
    input wire err_single_i,
    input wire err_double_i,
    input wire err_rmw_i,
    input wire err_lane_i,
    input wire [31:0] err_addr_i,
    input wire [127:0] err_data_i,
    input wire [15:0] err_syndrome_i,
    // steering toward the datapath
    output reg correct_en_o,
    output reg corrupt_en_o,
    output reg corrupt_double_o
);

// -----------------------------------------------------------------
// storage
// -----------------------------------------------------------------
// control word, thresholds and write-only mask
reg [31:0] ctrl;
reg [31:0] sb_thr;
reg [31:0] db_thr;
reg [31:0] sb_cnt;
reg [31:0] db_cnt;
reg [31:0] sb_addr;
reg [31:0] db_addr;
// interrupt causes, lane locations and the pending interrupt
reg [4:0] irq_stat;
reg [4:0] irq_mask;
reg [1:0] sb_lane;
reg [1:0] db_lane;
// held flags: an address is latched; in first-error mode it must not be replaced
reg sb_addr_held;
reg db_addr_held;
reg irq_pend;
// captured failing word as four 32-bit sub-words, one syndrome per lane
reg [31:0] sb_q [0:3];
reg [31:0] db_q [0:3];
reg [7:0] syn_q [0:1];
// read pointers step one sub-word per data read
reg [1:0] sb_rd_ptr;
reg [1:0] db_rd_ptr;
integer i;

// -----------------------------------------------------------------
// request decode
// -----------------------------------------------------------------
// one-cycle strobes for the registers that have side effects
wire wr_ctrl = reg_port_write_req_i && reg_port_addr_i == `EEM_OFS_CTRL;
wire clr_all = wr_ctrl && reg_port_wdata_i[`EEM_CTL_CLEAR_ALL];
wire rd_sb_cnt = reg_port_read_req_i && reg_port_addr_i == `EEM_OFS_SB_CNT;
wire rd_db_cnt = reg_port_read_req_i && reg_port_addr_i == `EEM_OFS_DB_CNT;
wire rd_sb_data = reg_port_read_req_i && reg_port_addr_i == `EEM_OFS_SB_DATA;
wire rd_db_data = reg_port_read_req_i && reg_port_addr_i == `EEM_OFS_DB_DATA;
wire wr_stat = reg_port_write_req_i && reg_port_addr_i == `EEM_OFS_IRQ_STAT;
wire wr_sb_lane = reg_port_write_req_i && reg_port_addr_i == `EEM_OFS_SB_LANE;
wire wr_db_lane = reg_port_write_req_i && reg_port_addr_i == `EEM_OFS_DB_LANE;

// qualified events
// a disabled double-bit check drops the event before any capture
wire sb_evt = err_single_i; // capture happens regardless of counting
wire db_evt = err_double_i && ctrl[`EEM_CTL_DB_ENABLE];
// max flags use the live threshold: lowering it below the count
// raises the cause with the next event, not at the write
wire sb_max = sb_cnt >= sb_thr;
wire db_max = db_cnt >= db_thr;

// byte-lane merge of a write onto an old value
// bytes whose enable is low keep their old contents
function [31:0] eem_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer k;
    begin
        eem_merge = old_v;
        for (k = 0; k < 4; k = k + 1)
            if (be[k])
                eem_merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
endfunction

// saturating count step, shared by both counters
// the counter parks at the threshold and never wraps to zero
function [31:0] eem_count;
    input [31:0] cnt;
    input [31:0] thr;
    input inc;
    begin
        if (inc && cnt < thr)
            eem_count = cnt + 32'h00000001;
        else
            eem_count = cnt;
    end
endfunction

// -----------------------------------------------------------------
// control, thresholds and mask
// -----------------------------------------------------------------
// clear-all and clear-interrupt bits are stored as written; only the
// write itself acts, so a read-back still shows them set
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        ctrl <= `EEM_RST_CTRL;
        sb_thr <= `EEM_RST_THR;
        db_thr <= `EEM_RST_THR;
        irq_mask <= `EEM_RST_MASK;
    end
    else if (reg_port_write_req_i)
    begin
        case (reg_port_addr_i)
            `EEM_OFS_CTRL:
                ctrl <= eem_merge(ctrl, reg_port_wdata_i, reg_port_byte_en_i);
            `EEM_OFS_SB_THR:
                sb_thr <= eem_merge(sb_thr, reg_port_wdata_i, reg_port_byte_en_i);
            `EEM_OFS_DB_THR:
                db_thr <= eem_merge(db_thr, reg_port_wdata_i, reg_port_byte_en_i);
            // the mask needs only its low byte lane
            `EEM_OFS_IRQ_MASK:
                if (reg_port_byte_en_i[0])
                    irq_mask <= reg_port_wdata_i[4:0];
            default:
                ;
        endcase
    end
end

// -----------------------------------------------------------------
// error counters
// -----------------------------------------------------------------
// a read-clear in the event cycle restarts from one so the event survives
// single-bit counting is gated here; capture further down is not
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        sb_cnt <= 32'h00000000;
        db_cnt <= 32'h00000000;
    end
    else
    begin
        if (clr_all || (rd_sb_cnt && ctrl[`EEM_CTL_CLR_ON_RD]))
            sb_cnt <= eem_count(32'h00000000, sb_thr, sb_evt && ctrl[`EEM_CTL_SB_COUNT]);
        else
            sb_cnt <= eem_count(sb_cnt, sb_thr, sb_evt && ctrl[`EEM_CTL_SB_COUNT]);
        if (clr_all || (rd_db_cnt && ctrl[`EEM_CTL_CLR_ON_RD]))
            db_cnt <= eem_count(32'h00000000, db_thr, db_evt);
        else
            db_cnt <= eem_count(db_cnt, db_thr, db_evt);
    end
end

// -----------------------------------------------------------------
// failing address capture
// -----------------------------------------------------------------
// in first-error mode the held flag blocks later captures until a
// clear-all; leaving that mode lets the next error overwrite
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        sb_addr <= 32'h00000000;
        db_addr <= 32'h00000000;
        sb_addr_held <= 1'b0;
        db_addr_held <= 1'b0;
    end
    else
    begin
        if (clr_all)
        begin
            sb_addr <= 32'h00000000;
            sb_addr_held <= 1'b0;
        end
        else if (sb_evt && !(ctrl[`EEM_CTL_KEEP_FIRST] && sb_addr_held))
        begin
            sb_addr <= err_addr_i;
            sb_addr_held <= 1'b1;
        end
        if (clr_all)
        begin
            db_addr <= 32'h00000000;
            db_addr_held <= 1'b0;
        end
        else if (db_evt && !(ctrl[`EEM_CTL_KEEP_FIRST] && db_addr_held))
        begin
            db_addr <= err_addr_i;
            db_addr_held <= 1'b1;
        end
    end
end

// -----------------------------------------------------------------
// data and syndrome queues
// -----------------------------------------------------------------
// each read of a data register steps to the next 32-bit sub-word and wraps;
// the syndrome shown follows the lane of the next single-error sub-word to be read
// a new event outranks a clear-all in the same cycle, so the
// freshest failing word is never thrown away
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            sb_q[i] <= 32'h00000000;
            db_q[i] <= 32'h00000000;
        end
        syn_q[0] <= 8'h00;
        syn_q[1] <= 8'h00;
        sb_rd_ptr <= 2'h0;
        db_rd_ptr <= 2'h0;
    end
    else
    begin
        if (sb_evt)
        begin
            for (i = 0; i < 4; i = i + 1)
                sb_q[i] <= err_data_i[i*32 +: 32];
            syn_q[0] <= err_syndrome_i[7:0];
            syn_q[1] <= err_syndrome_i[15:8];
            sb_rd_ptr <= 2'h0;
        end
        else if (clr_all)
        begin
            for (i = 0; i < 4; i = i + 1)
                sb_q[i] <= 32'h00000000;
            syn_q[0] <= 8'h00;
            syn_q[1] <= 8'h00;
            sb_rd_ptr <= 2'h0;
        end
        else if (rd_sb_data)
            sb_rd_ptr <= sb_rd_ptr + 2'h1;
        if (db_evt)
        begin
            for (i = 0; i < 4; i = i + 1)
                db_q[i] <= err_data_i[i*32 +: 32];
            db_rd_ptr <= 2'h0;
        end
        else if (clr_all)
        begin
            for (i = 0; i < 4; i = i + 1)
                db_q[i] <= 32'h00000000;
            db_rd_ptr <= 2'h0;
        end
        else if (rd_db_data)
            db_rd_ptr <= db_rd_ptr + 2'h1;
    end
end

// -----------------------------------------------------------------
// interrupt status, lane flags and interrupt output
// -----------------------------------------------------------------
// set wins over a write-one clear in the same cycle
wire [4:0] stat_set = {err_rmw_i && db_evt,
                       db_evt && db_max,
                       sb_evt && ctrl[`EEM_CTL_SB_COUNT] && sb_max,
                       db_evt,
                       sb_evt};
// only two lanes exist, so the lane input picks one of two bits
wire [1:0] lane_bit = err_lane_i ? 2'b10 : 2'b01;
// write-one-to-clear strobes; byte enables play no part here
wire [4:0] stat_clr = wr_stat ? reg_port_wdata_i[4:0] : 5'h00;
wire [1:0] sbl_clr = wr_sb_lane ? reg_port_wdata_i[1:0] : 2'h0;
wire [1:0] dbl_clr = wr_db_lane ? reg_port_wdata_i[1:0] : 2'h0;
wire [4:0] next_irq_stat = (irq_stat & ~stat_clr) | stat_set;

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        irq_stat <= 5'h00;
        sb_lane <= 2'h0;
        db_lane <= 2'h0;
        irq_pend <= 1'b0;
    end
    else
    begin
        irq_stat <= next_irq_stat;
        sb_lane <= (sb_lane & ~sbl_clr) | (sb_evt ? lane_bit : 2'h0);
        db_lane <= (db_lane & ~dbl_clr) | (db_evt ? lane_bit : 2'h0);
        // new unmasked cause re-arms; control bit 11 drops the line
        // pending also drops once no unmasked cause is left
        if (|(stat_set & ~irq_mask))
            irq_pend <= 1'b1;
        else if (wr_ctrl && reg_port_wdata_i[`EEM_CTL_CLR_IRQ])
            irq_pend <= 1'b0;
        else if (!(|(next_irq_stat & ~irq_mask)))
            irq_pend <= 1'b0;
    end
end

// -----------------------------------------------------------------
// outputs, all registered
// -----------------------------------------------------------------
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        reg_port_rdata_o <= 32'h00000000;
        reg_port_interrupt_o <= 1'b0;
        correct_en_o <= 1'b0;
        corrupt_en_o <= 1'b0;
        corrupt_double_o <= 1'b0;
    end
    else
    begin
        // steering outputs lag the control word by one cycle
        reg_port_interrupt_o <= irq_pend;
        correct_en_o <= ctrl[`EEM_CTL_SB_CORRECT];
        corrupt_en_o <= ctrl[`EEM_CTL_CORRUPT];
        corrupt_double_o <= ctrl[`EEM_CTL_CORR_TYPE];
        // side-effect reads return the value from before their step
        if (reg_port_read_req_i)
        begin
            case (reg_port_addr_i)
                `EEM_OFS_CTRL: reg_port_rdata_o <= ctrl;
                `EEM_OFS_SB_THR: reg_port_rdata_o <= sb_thr;
                `EEM_OFS_DB_THR: reg_port_rdata_o <= db_thr;
                `EEM_OFS_SB_CNT: reg_port_rdata_o <= sb_cnt;
                `EEM_OFS_DB_CNT: reg_port_rdata_o <= db_cnt;
                `EEM_OFS_SB_ADDR: reg_port_rdata_o <= sb_addr;
                `EEM_OFS_DB_ADDR: reg_port_rdata_o <= db_addr;
                `EEM_OFS_SB_DATA: reg_port_rdata_o <= sb_q[sb_rd_ptr];
                `EEM_OFS_SB_SYN: reg_port_rdata_o <= {24'h000000, syn_q[sb_rd_ptr[1]]};
                `EEM_OFS_DB_DATA: reg_port_rdata_o <= db_q[db_rd_ptr];
                `EEM_OFS_IRQ_STAT: reg_port_rdata_o <= {27'h0000000, irq_stat};
                `EEM_OFS_SB_LANE: reg_port_rdata_o <= {30'h00000000, sb_lane};
                `EEM_OFS_DB_LANE: reg_port_rdata_o <= {30'h00000000, db_lane};
                default: reg_port_rdata_o <= 32'h00000000; // mask is write-only
            endcase
        end
    end
end

endmodule
